// ---- tcwd_decode.sv ----
// Combinational decode of one seven-bit transfer control byte into the
// controls the transfer engine acts on. Assumes the byte is stable.
`timescale 1ns/1ps
`include "tcwd_params.svh"

module tcwd_decode (
   // Stored control byte, bit 7 excluded.
   input  wire logic [6:0] ctrl_i,
   // Decoded controls.
   output logic            unit_16bit_o,
   output logic            repeat_mode_o,
   output logic            repeat_irq_en_o,
   output logic            chain_o,
   output logic            src_inc_o,
   output logic            dst_inc_o,
   output logic            repeat_src_o
);

   // Masking of fields that the mode makes meaningless.
   always_comb begin
      unit_16bit_o    = ctrl_i[`TCWD_UNIT_WIDTH_BIT];
      repeat_mode_o   = ctrl_i[`TCWD_MODE_BIT];
      repeat_irq_en_o = ctrl_i[`TCWD_RPT_IRQ_EN_BIT] & ctrl_i[`TCWD_MODE_BIT];
      chain_o         = ctrl_i[`TCWD_CHAIN_BIT];
      repeat_src_o    = ctrl_i[`TCWD_RPT_AREA_BIT] & ctrl_i[`TCWD_MODE_BIT];
      dst_inc_o       = (ctrl_i[`TCWD_MODE_BIT] & ~ctrl_i[`TCWD_RPT_AREA_BIT])
                        | ctrl_i[`TCWD_DST_INC_BIT];
      src_inc_o       = (ctrl_i[`TCWD_MODE_BIT] & ctrl_i[`TCWD_RPT_AREA_BIT])
                        | ctrl_i[`TCWD_SRC_INC_BIT];
   end

endmodule : tcwd_decode

// ---- tcwd_engine_model.sv ----
// Behavioural model of the transfer engine: channel select and block ends.
// Assumes the decoder samples both requests on clk_i.
`timescale 1ns/1ps

module tcwd_engine_model (
   // Clock.
   input  wire logic clk_i,
   // Engine requests towards the decoder.
   output logic      ch_sel_o,
   output logic      block_done_o
);
   // Idle at time zero so the decoder never samples an unknown request.
   initial begin
      ch_sel_o     = 1'b0;
      block_done_o = 1'b0;
   end

   // The select changes just after an edge, so it stands a whole cycle.
   task automatic pick_channel(input logic ch);
      @(posedge clk_i);
      ch_sel_o <= ch;
   endtask : pick_channel

   // A block end lasts exactly one cycle, as the engine's own pulse does.
   task automatic finish_block();
      @(posedge clk_i);
      block_done_o <= 1'b1;
      @(posedge clk_i);
      block_done_o <= 1'b0;
   endtask : finish_block
endmodule : tcwd_engine_model

// ---- tcwd_irq.sv ----
// Sticky event status with write-one-to-clear, a mask and one level
// interrupt. Assumes events and clears are single-cycle pulses on the clock.
`timescale 1ns/1ps

module tcwd_irq #(
   parameter int          WIDTH      = 4,
   parameter logic [3:0]  MASK_RESET = 4'h0
) (
   // Clock and reset.
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Event pulses and software access.
   input  wire logic [WIDTH-1:0] event_i,
   input  wire logic [WIDTH-1:0] clear_i,
   input  wire logic             mask_wr_i,
   input  wire logic [WIDTH-1:0] mask_data_i,
   // State seen by software and the interrupt line.
   output logic      [WIDTH-1:0] status_o,
   output logic      [WIDTH-1:0] mask_o,
   output logic                  irq_o
);

   typedef struct packed {
      logic [WIDTH-1:0] status;
      logic [WIDTH-1:0] mask;
      logic             irq;
   } tcwd_irq_state_t;

   tcwd_irq_state_t st;
   tcwd_irq_state_t next_st;

   // A set arriving with its own clear wins, so no event is lost.
   always_comb begin
      next_st        = st;
      next_st.status = (st.status & ~clear_i) | event_i;
      if (mask_wr_i) begin
         next_st.mask = mask_data_i;
      end
      next_st.irq    = |(next_st.status & next_st.mask);
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st.status <= '0;
         st.mask   <= MASK_RESET[WIDTH-1:0];
         st.irq    <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign status_o = st.status;
   assign mask_o   = st.mask;
   assign irq_o    = st.irq;

endmodule : tcwd_irq

// ---- tcwd_params.svh ----
// Constants for the transfer control word decoder: register offsets,
// control byte field positions, reset values and interrupt bit positions.
// Assumes the includer works with byte addresses on a 32-bit register bus.
`ifndef TCWD_PARAMS_SVH
`define TCWD_PARAMS_SVH

// Register byte offsets.
`define TCWD_CH6_OFFSET    8'h00
`define TCWD_CH7_OFFSET    8'h04
`define TCWD_STATUS_OFFSET 8'h08
`define TCWD_MASK_OFFSET   8'h0C
`define TCWD_ACTIVE_OFFSET 8'h10

// Control byte field positions.
`define TCWD_UNIT_WIDTH_BIT  6
`define TCWD_RPT_IRQ_EN_BIT  5
`define TCWD_CHAIN_BIT       4
`define TCWD_DST_INC_BIT     3
`define TCWD_SRC_INC_BIT     2
`define TCWD_RPT_AREA_BIT    1
`define TCWD_MODE_BIT        0

// Reset values of the control bytes and interrupt registers.
`define TCWD_CH6_RESET    7'h50
`define TCWD_CH7_RESET    7'h10
`define TCWD_STATUS_RESET 4'h0
`define TCWD_MASK_RESET   4'h0

// Status and mask bit positions.
`define TCWD_ST_RPT_CH6   0
`define TCWD_ST_RPT_CH7   1
`define TCWD_ST_END_CH6   2
`define TCWD_ST_END_CH7   3

// Bus responses.
`define TCWD_RESP_OKAY   2'h0
`define TCWD_RESP_SLVERR 2'h2

`endif

// ---- tcwd_pkg.sv ----
// Types shared by the transfer control word decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package tcwd_pkg;

   // Write channel states, one-hot.
   typedef enum logic [1:0] {
      TCWD_WR_IDLE = 2'h1,
      TCWD_WR_RESP = 2'h2
   } tcwd_wr_state_t;

   // Read channel states, one-hot.
   typedef enum logic [1:0] {
      TCWD_RD_IDLE = 2'h1,
      TCWD_RD_DATA = 2'h2
   } tcwd_rd_state_t;

endpackage : tcwd_pkg

// ---- tcwd_top.sv ----
// Transfer control word decoder: holds the control bytes of two transfer
// channels behind an AXI4-Lite slave, presents the decoded controls of the
// channel that the transfer engine has selected, and raises interrupts on
// repeat-mode block ends and on chain ends.
// Assumes the engine runs on CLOCK_I and drives CH_SEL_I and BLOCK_DONE_I
// from logic on the same clock, so they are not synchronised here.
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "tcwd_params.svh"

module tcwd_top (
   // Clock and synchronous reset.
   input  wire logic        CLOCK_I,
   input  wire logic        RST_I,
   // AXI4-Lite write address channel.
   input  wire logic        AXI_AWVALID_I,
   output logic             AXI_AWREADY_O,
   input  wire logic [7:0]  AXI_AWADDR_I,
   // AXI4-Lite write data channel.
   input  wire logic        AXI_WVALID_I,
   output logic             AXI_WREADY_O,
   input  wire logic [31:0] AXI_WDATA_I,
   input  wire logic [3:0]  AXI_WSTRB_I,
   // AXI4-Lite write response channel.
   output logic             AXI_BVALID_O,
   input  wire logic        AXI_BREADY_I,
   output logic [1:0]       AXI_BRESP_O,
   // AXI4-Lite read address channel.
   input  wire logic        AXI_ARVALID_I,
   output logic             AXI_ARREADY_O,
   input  wire logic [7:0]  AXI_ARADDR_I,
   // AXI4-Lite read data channel.
   output logic             AXI_RVALID_O,
   input  wire logic        AXI_RREADY_I,
   output logic [31:0]      AXI_RDATA_O,
   output logic [1:0]       AXI_RRESP_O,
   // Transfer engine side.
   input  wire logic        CH_SEL_I,
   input  wire logic        BLOCK_DONE_I,
   output logic             UNIT_16BIT_O,
   output logic             REPEAT_MODE_O,
   output logic             REPEAT_SRC_O,
   output logic             SRC_INC_O,
   output logic             DST_INC_O,
   output logic             CHAIN_NEXT_O,
   output logic             REPEAT_IRQ_O,
   // Interrupt.
   output logic             IRQ_O
);

   // Everything the module remembers outside the interrupt block, registered as one word.
   typedef struct packed {
      tcwd_pkg::tcwd_wr_state_t wr;
      tcwd_pkg::tcwd_rd_state_t rd;
      logic                     awready;
      logic                     aw_held;
      logic [7:0]               aw_addr;
      logic                     wready;
      logic                     w_held;
      logic [31:0]              w_data;
      logic [3:0]               w_strb;
      logic [1:0]               bresp;
      logic                     arready;
      logic [31:0]              rdata;
      logic [1:0]               rresp;
      logic [6:0]               ch6;
      logic [6:0]               ch7;
      logic                     unit_16bit;
      logic                     repeat_mode;
      logic                     repeat_src;
      logic                     src_inc;
      logic                     dst_inc;
      logic                     chain_next;
      logic                     repeat_irq;
   } tcwd_top_state_t;

   tcwd_top_state_t st;
   tcwd_top_state_t next_st;

   // Decoded controls of each channel.
   logic [1:0] dec_unit_16bit;
   logic [1:0] dec_repeat_mode;
   logic [1:0] dec_irq_en;
   logic [1:0] dec_chain;
   logic [1:0] dec_src_inc;
   logic [1:0] dec_dst_inc;
   logic [1:0] dec_repeat_src;

   // Interrupt block connections.
   logic [3:0] irq_event;
   logic [3:0] irq_clear;
   logic       irq_mask_wr;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic       irq_line;

   // Helpers for the write and read decode.
   logic       wr_fire;
   logic       rd_fire;
   logic [1:0] sel_onehot;

   // True when a byte address names a mapped register.
   function automatic logic tcwd_mapped(input logic [7:0] addr);
      tcwd_mapped = (addr == `TCWD_CH6_OFFSET)
                 || (addr == `TCWD_CH7_OFFSET)
                 || (addr == `TCWD_STATUS_OFFSET)
                 || (addr == `TCWD_MASK_OFFSET)
                 || (addr == `TCWD_ACTIVE_OFFSET);
   endfunction : tcwd_mapped

   // Upper byte lanes carry nothing, so they are ignored on purpose.
   // Stored byte with the low lane enable applied; bit 7 never stored.
   function automatic logic [6:0] tcwd_merge(input logic [6:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
      tcwd_merge = strb[0] ? data[6:0] : old;
   endfunction : tcwd_merge

   // One decoder per channel; the engine may switch channels every cycle.
   // Two decoders cost a little area, but the select mux then sits after
   // the decode, so a channel switch shows after a single edge.
   tcwd_decode u_dec6 (
      .ctrl_i          (st.ch6),
      .unit_16bit_o    (dec_unit_16bit[0]),
      .repeat_mode_o   (dec_repeat_mode[0]),
      .repeat_irq_en_o (dec_irq_en[0]),
      .chain_o         (dec_chain[0]),
      .src_inc_o       (dec_src_inc[0]),
      .dst_inc_o       (dec_dst_inc[0]),
      .repeat_src_o    (dec_repeat_src[0])
   );

   tcwd_decode u_dec7 (
      .ctrl_i          (st.ch7),
      .unit_16bit_o    (dec_unit_16bit[1]),
      .repeat_mode_o   (dec_repeat_mode[1]),
      .repeat_irq_en_o (dec_irq_en[1]),
      .chain_o         (dec_chain[1]),
      .src_inc_o       (dec_src_inc[1]),
      .dst_inc_o       (dec_dst_inc[1]),
      .repeat_src_o    (dec_repeat_src[1])
   );

   // A write lands when both halves are held and no response is pending.
   // A second address may be caught while the response waits; it is then
   // held, with ready low, until the master has taken the response.
   assign wr_fire   = (st.wr == tcwd_pkg::TCWD_WR_IDLE) && st.aw_held && st.w_held;
   assign rd_fire   = (st.rd == tcwd_pkg::TCWD_RD_IDLE) && AXI_ARVALID_I && st.arready;
   assign sel_onehot = CH_SEL_I ? 2'h2 : 2'h1;

   // Block-end events of the selected channel.
   // A block end is charged to the channel selected in the same cycle, so
   // the engine must raise its pulse before it moves to another channel.
   always_comb begin
      irq_event[`TCWD_ST_RPT_CH6] = BLOCK_DONE_I && sel_onehot[0] && dec_irq_en[0];
      irq_event[`TCWD_ST_RPT_CH7] = BLOCK_DONE_I && sel_onehot[1] && dec_irq_en[1];
      irq_event[`TCWD_ST_END_CH6] = BLOCK_DONE_I && sel_onehot[0] && !dec_chain[0];
      irq_event[`TCWD_ST_END_CH7] = BLOCK_DONE_I && sel_onehot[1] && !dec_chain[1];
   end

   // Software side of the interrupt block, qualified by the low lane.
   // A clear that meets a new event of the same bit loses inside the
   // interrupt block, so a late acknowledge never hides an event.
   always_comb begin
      irq_clear   = 4'h0;
      irq_mask_wr = 1'b0;
      if (wr_fire && st.w_strb[0]) begin
         if (st.aw_addr == `TCWD_STATUS_OFFSET) begin
            irq_clear = st.w_data[3:0];
         end
         if (st.aw_addr == `TCWD_MASK_OFFSET) begin
            irq_mask_wr = 1'b1;
         end
      end
   end

   tcwd_irq #(
      .WIDTH      (4),
      .MASK_RESET (`TCWD_MASK_RESET)
   ) u_irq (
      .clk_i       (CLOCK_I),
      .rst_i       (RST_I),
      .event_i     (irq_event),
      .clear_i     (irq_clear),
      .mask_wr_i   (irq_mask_wr),
      .mask_data_i (st.w_data[3:0]),
      .status_o    (irq_status),
      .mask_o      (irq_mask),
      .irq_o       (irq_line)
   );

   // Next state: bus channels, register writes, reads and engine outputs.
   always_comb begin
      next_st = st;

      // Address and data are caught independently, in either order.
      if (AXI_AWVALID_I && st.awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = AXI_AWADDR_I;
      end
      if (AXI_WVALID_I && st.wready) begin
         next_st.w_held = 1'b1;
         next_st.w_data = AXI_WDATA_I;
         next_st.w_strb = AXI_WSTRB_I;
      end

      // Register write and response.
      unique case (st.wr)
         tcwd_pkg::TCWD_WR_IDLE: begin
            if (wr_fire) begin
               next_st.aw_held = 1'b0;
               next_st.w_held  = 1'b0;
               next_st.wr      = tcwd_pkg::TCWD_WR_RESP;
               next_st.bresp   = tcwd_mapped(st.aw_addr) ? `TCWD_RESP_OKAY
                                                         : `TCWD_RESP_SLVERR;
               if (st.aw_addr == `TCWD_CH6_OFFSET) begin
                  next_st.ch6 = tcwd_merge(st.ch6, st.w_data, st.w_strb);
               end
               if (st.aw_addr == `TCWD_CH7_OFFSET) begin
                  next_st.ch7 = tcwd_merge(st.ch7, st.w_data, st.w_strb);
               end
            end
         end
         tcwd_pkg::TCWD_WR_RESP: begin
            if (AXI_BREADY_I) begin
               next_st.wr = tcwd_pkg::TCWD_WR_IDLE;
            end
         end
      endcase

      // Registering readiness costs an idle cycle per write, but keeps the
      // ready outputs free of any path from the bus inputs.
      // Readiness is registered; it drops once a half is held.
      next_st.awready = !next_st.aw_held;
      next_st.wready  = !next_st.w_held;

      // Register read; the data word is captured at the address handshake.
      // Reads have no side effects, so reading the status register never
      // disturbs a pending interrupt.
      unique case (st.rd)
         tcwd_pkg::TCWD_RD_IDLE: begin
            if (rd_fire) begin
               next_st.rd    = tcwd_pkg::TCWD_RD_DATA;
               next_st.rresp = tcwd_mapped(AXI_ARADDR_I) ? `TCWD_RESP_OKAY
                                                         : `TCWD_RESP_SLVERR;
               next_st.rdata = 32'h0;
               if (AXI_ARADDR_I == `TCWD_CH6_OFFSET) begin
                  next_st.rdata = {25'h0, st.ch6};
               end
               if (AXI_ARADDR_I == `TCWD_CH7_OFFSET) begin
                  next_st.rdata = {25'h0, st.ch7};
               end
               if (AXI_ARADDR_I == `TCWD_STATUS_OFFSET) begin
                  next_st.rdata = {28'h0, irq_status};
               end
               if (AXI_ARADDR_I == `TCWD_MASK_OFFSET) begin
                  next_st.rdata = {28'h0, irq_mask};
               end
               // The active view reports the live select in bit 0 beside the
               // registered controls, so bit 0 may lead the others by a cycle.
               if (AXI_ARADDR_I == `TCWD_ACTIVE_OFFSET) begin
                  next_st.rdata = {24'h0, st.repeat_irq, st.chain_next,
                                   st.dst_inc, st.src_inc, st.repeat_src,
                                   st.repeat_mode, st.unit_16bit, CH_SEL_I};
               end
            end
         end
         tcwd_pkg::TCWD_RD_DATA: begin
            if (AXI_RREADY_I) begin
               next_st.rd = tcwd_pkg::TCWD_RD_IDLE;
            end
         end
      endcase
      next_st.arready = (next_st.rd == tcwd_pkg::TCWD_RD_IDLE);

      // Engine controls follow the selected channel one cycle later; the
      // engine is expected to hold its selection while it works.
      // A channel switch shows at the outputs after one edge; the engine
      // must not act on the controls in that cycle.
      // unit width out
      next_st.unit_16bit  = CH_SEL_I ? dec_unit_16bit[1] : dec_unit_16bit[0];
      next_st.repeat_mode = CH_SEL_I ? dec_repeat_mode[1] : dec_repeat_mode[0];
      next_st.repeat_src  = CH_SEL_I ? dec_repeat_src[1] : dec_repeat_src[0];
      next_st.src_inc     = CH_SEL_I ? dec_src_inc[1] : dec_src_inc[0];
      next_st.dst_inc     = CH_SEL_I ? dec_dst_inc[1] : dec_dst_inc[0];
      next_st.chain_next  = CH_SEL_I ? dec_chain[1] : dec_chain[0];
      next_st.repeat_irq  = irq_event[`TCWD_ST_RPT_CH6] | irq_event[`TCWD_ST_RPT_CH7];
   end

   // State register; the control bytes return to their set-up values on reset, the decoded controls to zero.
   // The reset branch writes constants only, so reset needs no valid
   // bus or engine inputs.
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         st             <= '0;
         st.wr          <= tcwd_pkg::TCWD_WR_IDLE;
         st.rd          <= tcwd_pkg::TCWD_RD_IDLE;
         st.awready     <= 1'b1;
         st.wready      <= 1'b1;
         st.arready     <= 1'b1;
         st.ch6         <= `TCWD_CH6_RESET;
         st.ch7         <= `TCWD_CH7_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from the state register, IRQ_O from the interrupt block's register.
   // Valid flags are the one-hot state bits themselves, not a decode.
   assign AXI_AWREADY_O = st.awready;
   assign AXI_WREADY_O  = st.wready;
   assign AXI_BVALID_O  = st.wr[1];
   assign AXI_BRESP_O   = st.bresp;
   assign AXI_ARREADY_O = st.arready;
   assign AXI_RVALID_O  = st.rd[1];
   assign AXI_RDATA_O   = st.rdata;
   assign AXI_RRESP_O   = st.rresp;
   assign UNIT_16BIT_O  = st.unit_16bit;
   assign REPEAT_MODE_O = st.repeat_mode;
   assign REPEAT_SRC_O  = st.repeat_src;
   assign SRC_INC_O     = st.src_inc;
   assign DST_INC_O     = st.dst_inc;
   assign CHAIN_NEXT_O  = st.chain_next;
   assign REPEAT_IRQ_O  = st.repeat_irq;
   assign IRQ_O         = irq_line;

endmodule : tcwd_top

// ---- tcwd_top_sva.sv ----
// Concurrent checks on the ports of the transfer control word decoder.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module tcwd_checker (
   // Clock and reset.
   input wire logic        CLOCK_I,
   input wire logic        RST_I,
   // Register bus.
   input wire logic        AXI_AWVALID_I,
   input wire logic        AXI_AWREADY_O,
   input wire logic        AXI_WVALID_I,
   input wire logic        AXI_WREADY_O,
   input wire logic        AXI_BVALID_O,
   input wire logic        AXI_BREADY_I,
   input wire logic [1:0]  AXI_BRESP_O,
   input wire logic        AXI_ARVALID_I,
   input wire logic        AXI_ARREADY_O,
   input wire logic        AXI_RVALID_O,
   input wire logic        AXI_RREADY_I,
   input wire logic [31:0] AXI_RDATA_O,
   // Engine side.
   input wire logic        BLOCK_DONE_I,
   input wire logic        REPEAT_MODE_O,
   input wire logic        REPEAT_SRC_O,
   input wire logic        SRC_INC_O,
   input wire logic        DST_INC_O,
   input wire logic        REPEAT_IRQ_O
);
   // Everything runs on one clock, so one default covers all checks.
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);

   // Both halves of a write taken at one edge.
   sequence s_wr_taken;
      AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O;
   endsequence

   // A read address taken.
   sequence s_rd_taken;
      AXI_ARVALID_I && AXI_ARREADY_O;
   endsequence

   // Bus answers come in bounded time and stand until taken.
   chk_write_answer: assert property (s_wr_taken |-> ##[1:2] AXI_BVALID_O)
      else $error("write response late");
   chk_read_answer: assert property (s_rd_taken |=> AXI_RVALID_O && !AXI_ARREADY_O)
      else $error("read data late");
   chk_bresp_hold: assert property (AXI_BVALID_O && !AXI_BREADY_I |=>
      AXI_BVALID_O && $stable(AXI_BRESP_O)) else $error("write response dropped");
   chk_rdata_hold: assert property (AXI_RVALID_O && !AXI_RREADY_I |=>
      AXI_RVALID_O && $stable(AXI_RDATA_O)) else $error("read data dropped");

   // Repeat requests only follow a block end in repeat mode, one cycle long.
   chk_rpt_cause: assert property (REPEAT_IRQ_O |-> $past(BLOCK_DONE_I))
      else $error("repeat request without block end");
   chk_rpt_in_mode: assert property (REPEAT_IRQ_O |-> REPEAT_MODE_O)
      else $error("repeat request in normal mode");
   chk_rpt_single: assert property (REPEAT_IRQ_O && !BLOCK_DONE_I |=> !REPEAT_IRQ_O)
      else $error("repeat request too long");

   // The repeat area overrides the increment of its own side only.
   chk_area_normal: assert property (!REPEAT_MODE_O |-> !REPEAT_SRC_O)
      else $error("repeat area seen in normal mode");
   chk_dst_area: assert property (REPEAT_MODE_O && !REPEAT_SRC_O |-> DST_INC_O)
      else $error("destination area not walked");
   chk_src_area: assert property (REPEAT_MODE_O && REPEAT_SRC_O |-> SRC_INC_O)
      else $error("source area not walked");
endmodule : tcwd_checker

bind tcwd_top tcwd_checker chk (.*);

// ---- transfer_control_word_decode_bench.sv ----
// Self-checking bench for the transfer control word decoder.
// Assumes the engine model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "tcwd_params.svh"

module transfer_control_word_decode_bench;
   logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic [7:0]  awa = 8'h00, ara = 8'h00, a;
   logic [31:0] wd = 32'h0, rdat, d;
   logic [3:0]  ws = 4'hF;
   logic        awr, wrd, bv, arr, rv, u16, rmode, rsrc, sinc, dinc, chn, rirq, irq, sel, done;
   logic [1:0]  bresp, rresp, r;
   int          failures = 0, checked = 0, cycles = 0;
   // Control bytes and their decode {unit16, repeat, src area, src inc, dst inc, chain}.
   logic [7:0]  ctrl_tab [10] = '{8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h05, 8'h03,
                                  8'h0B, 8'hFF};
   logic [5:0]  exp_tab [10] = '{6'h20, 6'h01, 6'h02, 6'h04, 6'h00, 6'h12, 6'h16, 6'h1C,
                                 6'h1E, 6'h3F};
   logic [31:0] rst_tab [4] = '{32'h50, 32'h10, 32'h0, 32'h0};

   // Free-running clock at 250 MHz.
   always #2 clk = ~clk;

   tcwd_top dut (.CLOCK_I(clk), .RST_I(rst),
      .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr), .AXI_AWADDR_I(awa),
      .AXI_WVALID_I(wv), .AXI_WREADY_O(wrd), .AXI_WDATA_I(wd), .AXI_WSTRB_I(ws),
      .AXI_BVALID_O(bv), .AXI_BREADY_I(br), .AXI_BRESP_O(bresp),
      .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_ARADDR_I(ara),
      .AXI_RVALID_O(rv), .AXI_RREADY_I(rr), .AXI_RDATA_O(rdat), .AXI_RRESP_O(rresp),
      .CH_SEL_I(sel), .BLOCK_DONE_I(done), .UNIT_16BIT_O(u16), .REPEAT_MODE_O(rmode),
      .REPEAT_SRC_O(rsrc), .SRC_INC_O(sinc), .DST_INC_O(dinc), .CHAIN_NEXT_O(chn),
      .REPEAT_IRQ_O(rirq), .IRQ_O(irq));

   tcwd_engine_model eng (.clk_i(clk), .ch_sel_o(sel), .block_done_o(done));

   // Compare one value and count it.
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   // Write one word; address and data are offered together and released when taken.
   task automatic wr(input logic [7:0] adr, input logic [31:0] v);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p  = 1'b1;
      @(posedge clk);
      awv <= 1'b1;
      awa <= adr;
      wv  <= 1'b1;
      wd  <= v;
      while (aw_p || w_p) begin
         @(posedge clk);
         if (aw_p && awr) begin
            aw_p = 1'b0;
            awv <= 1'b0;
         end
         if (w_p && wrd) begin
            w_p = 1'b0;
            wv  <= 1'b0;
         end
      end
      // Ready is raised late on purpose so the response must stand meanwhile.
      do @(posedge clk); while (bv !== 1'b1);
      br <= 1'b1;
      @(posedge clk);
      r = bresp;
      br <= 1'b0;
   endtask : wr

   // Read one word into d and its response into r.
   task automatic rd(input logic [7:0] adr);
      @(posedge clk);
      arv <= 1'b1;
      ara <= adr;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rv !== 1'b1);
      rr <= 1'b1;
      @(posedge clk);
      d = rdat;
      r = rresp;
      rr <= 1'b0;
   endtask : rd

   // Print the counts and the verdict, then stop.
   task automatic report_and_stop();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   // A hang costs a mismatch; the whole run needs well under 2000 cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         report_and_stop();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // Reset values of both control bytes, status and mask.
      for (int k = 0; k < 4; k++) begin
         rd(8'(k * 4));
         chk("reset value", d, rst_tab[k]);
      end
      // Decode table, rows alternating between the two channels.
      for (int i = 0; i < 10; i++) begin
         a = i[0] ? `TCWD_CH7_OFFSET : `TCWD_CH6_OFFSET;
         wr(a, {24'h0, ctrl_tab[i]});
         eng.pick_channel(i[0]);
         repeat (3) @(posedge clk);
         chk("decoded controls", {u16, rmode, rsrc, sinc, dinc, chn}, exp_tab[i]);
         rd(a);
         chk("control readback", d, {25'h0, ctrl_tab[i][6:0]});
      end
      // last entry: channel seven stands last, so its chain bit is written clear.
      wr(`TCWD_CH7_OFFSET, 32'h21);
      wr(`TCWD_MASK_OFFSET, 32'h2);
      eng.finish_block();
      #1 chk("repeat request", rirq, 32'h1);
      chk("interrupt line", irq, 32'h1);
      rd(`TCWD_STATUS_OFFSET);
      chk("status after end", d, 32'hA);
      wr(`TCWD_STATUS_OFFSET, 32'h2);
      rd(`TCWD_STATUS_OFFSET);
      chk("status after clear", d, 32'h8);
      chk("masked line", irq, 32'h0);
      wr(`TCWD_MASK_OFFSET, 32'h8);
      rd(`TCWD_STATUS_OFFSET);
      chk("unmasked line", irq, 32'h1);
      wr(`TCWD_STATUS_OFFSET, 32'hF);
      chk("quiet line", irq, 32'h0);
      wr(`TCWD_CH7_OFFSET, 32'h01);
      eng.finish_block();
      #1 chk("disabled request", rirq, 32'h0);
      wr(`TCWD_CH7_OFFSET, 32'h20);
      eng.finish_block();
      #1 chk("normal mode request", rirq, 32'h0);
      // chained block ends raise no end event.
      eng.pick_channel(1'b0);
      wr(`TCWD_CH6_OFFSET, 32'h10);
      wr(`TCWD_STATUS_OFFSET, 32'hF);
      eng.finish_block();
      rd(`TCWD_STATUS_OFFSET);
      chk("chained end", d, 32'h0);
      // Unmapped address is refused both ways.
      wr(8'h20, 32'h7F);
      chk("unmapped write", r, `TCWD_RESP_SLVERR);
      rd(8'h20);
      chk("unmapped read", r, `TCWD_RESP_SLVERR);
      chk("unmapped data", d, 32'h0);
      // Mid-run reset brings back the set-up bytes and their decode.
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(`TCWD_CH6_OFFSET);
      chk("reset again", d, 32'h50);
      chk("decode after reset", {u16, rmode, rsrc, sinc, dinc, chn}, 6'h21);
      chk("line after reset", irq, 32'h0);
      rd(`TCWD_ACTIVE_OFFSET);
      chk("active view", d, 32'h42);
      // A write without the low lane is accepted but leaves the byte alone.
      ws <= 4'hE;
      wr(`TCWD_CH6_OFFSET, 32'h7F);
      chk("laneless write", r, `TCWD_RESP_OKAY);
      ws <= 4'hF;
      rd(`TCWD_CH6_OFFSET);
      chk("laneless byte", d, 32'h50);
      report_and_stop();
   end
endmodule : transfer_control_word_decode_bench
